// file: verilog/adcrc_pkg.sv
// Package of constants and types for the converter result and accumulation control block
package adcrc_pkg;
    // ------------------------------------------------------------
    // Register offsets (byte addresses, one word each)
    // ------------------------------------------------------------
    localparam logic [9:0] OFS_CTRL = 10'h000; // justify, addition count, average, selftest level
    localparam logic [9:0] OFS_EXT = 10'h004; // temp/iref accumulate, group triggers
    localparam logic [9:0] OFS_STATUS = 10'h008; // sticky event bits, write one to clear
    localparam logic [9:0] OFS_MASK = 10'h00c; // interrupt mask
    localparam logic [9:0] OFS_WINB_CH = 10'h010; // window B channel select
    localparam logic [9:0] OFS_WINB_LO = 10'h014; // window B lower level
    localparam logic [9:0] OFS_WINB_HI = 10'h018; // window B upper level
    localparam logic [9:0] OFS_WINB_ST = 10'h01c; // window B channel status
    localparam logic [9:0] OFS_WINMON = 10'h020; // window A/B status monitor
    localparam logic [9:0] OFS_BUF_EN = 10'h024; // ring buffer enable
    localparam logic [9:0] OFS_BUF_PTR = 10'h028; // ring buffer pointer
    localparam logic [9:0] OFS_DUP = 10'h02c; // duplicate result
    localparam logic [9:0] OFS_TEMP = 10'h030; // temperature result
    localparam logic [9:0] OFS_IREF = 10'h034; // internal reference result
    localparam logic [9:0] OFS_WINA_LO = 10'h038; // window A lower level
    localparam logic [9:0] OFS_WINA_HI = 10'h03c; // window A upper level
    localparam logic [9:0] OFS_SST_BASE = 10'h040; // sample time 0..8, then L, T, O
    localparam logic [9:0] OFS_CH_BASE = 10'h100; // channel results 0..31
    localparam logic [9:0] OFS_BUF_BASE = 10'h200; // ring buffer slots 0..15
    localparam logic [3:0] SST_L = 4'h9;
    localparam logic [3:0] SST_T = 4'ha;
    localparam logic [3:0] SST_O = 4'hb;
    localparam logic [7:0] SST_RESET = 8'h0d; // default sampling states
    localparam logic [4:0] CH_GAP_LO = 5'h09;
    localparam logic [4:0] CH_GAP_HI = 5'h0f;
    // Addition count codes
    localparam logic [2:0] ADD_1 = 3'h0;
    localparam logic [2:0] ADD_2 = 3'h1;
    localparam logic [2:0] ADD_3 = 3'h2;
    localparam logic [2:0] ADD_4 = 3'h3;
    localparam logic [2:0] ADD_16 = 3'h5;
    // Self-diagnosis levels
    localparam logic [1:0] DIAG_0V = 2'h1;
    localparam logic [1:0] DIAG_HALF = 2'h2;
    localparam logic [1:0] DIAG_FULL = 2'h3;
    // Status bit positions
    localparam int ST_RESULT = 0;
    localparam int ST_WINA = 1;
    localparam int ST_WINB = 2;
    localparam int ST_WRAP = 3;
    // Result source of a conversion
    typedef enum logic [1:0] {
        ADCRC_SRC_CH = 2'b00,
        ADCRC_SRC_TEMP = 2'b01,
        ADCRC_SRC_IREF = 2'b10,
        ADCRC_SRC_DUP = 2'b11
    } adcrc_src_t;
    // One raw conversion from the analog core
    typedef struct packed {
        logic valid;
        adcrc_src_t src;
        logic [4:0] chan;
        logic [11:0] data;
    } adcrc_conv_t;
    // Formatting controls
    typedef struct packed {
        logic justify_left;
        logic [2:0] add_count;
        logic avg_en;
    } adcrc_fmt_t;
endpackage

// file: verilog/adcrc_accum.sv
// Accumulator that sums repeated conversions and formats the finished result
`timescale 1ns/100ps
`default_nettype none
module adcrc_accum (
    input wire logic sys_clk, // System clock
    input wire logic nrst, // Asynchronous reset, active low
    input wire logic in_valid, // One raw conversion
    input wire logic [11:0] in_data, // Raw 12-bit sample
    input wire logic accum_on, // Source takes part in addition
    input wire adcrc_pkg::adcrc_fmt_t fmt, // Formatting controls
    output logic out_valid, // Finished result pulse
    output logic [15:0] out_data // Formatted result
);
    typedef struct packed {
        logic [4:0] cnt;
        logic [15:0] sum;
        logic ovalid;
        logic [15:0] odata;
    } adcrc_acc_state_t;
    adcrc_acc_state_t st, next_st;
    logic [4:0] need;
    logic [15:0] total;
    logic [15:0] value;
    // --------------------------------------------------------
    // Number of conversions per result
    // --------------------------------------------------------
    always_comb begin
        case (fmt.add_count)
            adcrc_pkg::ADD_1: need = 5'h01;
            adcrc_pkg::ADD_2: need = 5'h02;
            adcrc_pkg::ADD_3: need = 5'h03;
            adcrc_pkg::ADD_4: need = 5'h04;
            adcrc_pkg::ADD_16: need = 5'h10;
            default: need = 5'h01; // Forbidden codes act as one conversion
        endcase
        if (!accum_on) begin
            need = 5'h01;
        end
    end
    // Sum, then justify; the sum is 14 or 16 bits wide so it never overflows
    always_comb begin
        next_st = st;
        next_st.ovalid = 1'b0;
        total = st.sum + {4'h0, in_data};
        value = total;
        if (fmt.avg_en) begin
            case (need)
                5'h02: value = total >> 1;
                5'h04: value = total >> 2;
                5'h10: value = total >> 4;
                5'h03: value = 16'((32'(total) * 32'h0000_0155) >> 10); // Close to divide by three, wide product
                default: value = total;
            endcase
        end
        if (in_valid) begin
            if (st.cnt + 5'h01 >= need) begin
                next_st.cnt = 5'h00;
                next_st.sum = 16'h0000;
                next_st.ovalid = 1'b1;
                if (fmt.justify_left) begin
                    // left justify keeps width of the sum at the top
                    if (fmt.avg_en || need == 5'h01) begin
                        next_st.odata = {value[11:0], 4'h0};
                    end else if (fmt.add_count == adcrc_pkg::ADD_16) begin
                        next_st.odata = value;
                    end else begin
                        next_st.odata = {value[13:0], 2'h0};
                    end
                end else begin
                    next_st.odata = value;
                end
            end else begin
                next_st.cnt = st.cnt + 5'h01;
                next_st.sum = total;
            end
        end
    end
    // State register
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    assign out_valid = st.ovalid;
    assign out_data = st.odata;
    // A single conversion with no partial sum comes out right-justified unchanged
    AST_ONE_SHOT: assert property (@(posedge sys_clk) disable iff (!nrst)
        (in_valid && st.cnt == 5'h00 && fmt.add_count == adcrc_pkg::ADD_1 && !fmt.justify_left)
        |=> (out_valid && out_data == {4'h0, $past(in_data)}))
        else $error("single conversion result wrong");
endmodule
`default_nettype wire

// file: verilog/adcrc_top.sv
// Result, accumulation, window and ring buffer control of the converter
//
// Decided for this implementation: the register offsets and the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none
module adcrc_top (
    input wire logic sys_clk, // System clock, 250 MHz
    input wire logic nrst, // Asynchronous reset, active low
    input wire logic [9:0] avs_address, // Byte address
    input wire logic avs_read, // Read request
    input wire logic avs_write, // Write request
    input wire logic [31:0] avs_writedata, // Write data
    input wire logic [3:0] avs_byteenable, // Byte lanes
    output logic [31:0] avs_readdata, // Read data
    output logic avs_waitrequest, // Stall
    input wire adcrc_pkg::adcrc_conv_t conv, // Raw conversion from core
    input wire logic sampling, // Core is sampling
    input wire logic compare_en, // Compare function in use
    output logic [1:0] selftest_level_select, // Self-diagnosis level to core
    output logic [5:0] group_a_trigger_select, // Group A start source
    output logic [5:0] group_b_trigger_select, // Group B start source
    output logic dac_sync_enable, // D/A update allowed
    output logic irq // Level interrupt
);
    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        adcrc_pkg::adcrc_fmt_t fmt;
        logic [1:0] diag;
        logic temp_acc;
        logic iref_acc;
        logic [5:0] trig_a;
        logic [5:0] trig_b;
        logic [3:0] status;
        logic [3:0] mask;
        logic [4:0] winb_ch;
        logic [15:0] winb_lo;
        logic [15:0] winb_hi;
        logic [15:0] wina_lo;
        logic [15:0] wina_hi;
        logic winb_st;
        logic wina_st;
        logic buf_en;
        logic [3:0] buf_ptr;
        logic [11:0][7:0] sst;
        logic [31:0][15:0] chres;
        logic [15:0][15:0] ring;
        logic [15:0] dup;
        logic [15:0] temp;
        logic [15:0] iref;
        logic dac_en;
    } adcrc_state_t;
    adcrc_state_t st, next_st;
    logic acc_valid;
    logic [15:0] acc_data;
    logic acc_on;
    adcrc_pkg::adcrc_src_t src_q;
    logic [4:0] chan_q;
    logic [31:0] wd;
    logic [3:0] hit;
    logic [3:0] w1c;
    logic in_a;
    logic in_b;
    // ------------------------------------------------------------
    // Accumulation of repeated conversions
    // ------------------------------------------------------------
    // Temperature and reference inputs each have their own include bit
    always_comb begin
        case (conv.src)
            adcrc_pkg::ADCRC_SRC_TEMP: acc_on = st.temp_acc;
            adcrc_pkg::ADCRC_SRC_IREF: acc_on = st.iref_acc;
            default: acc_on = 1'b1;
        endcase
    end
    adcrc_accum u_accum (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .in_valid(conv.valid),
        .in_data(conv.data),
        .accum_on(acc_on),
        .fmt(st.fmt),
        .out_valid(acc_valid),
        .out_data(acc_data)
    );
    // Source and channel of the conversion in flight; core keeps them steady per result
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            src_q <= adcrc_pkg::ADCRC_SRC_CH;
            chan_q <= 5'h00;
        end else if (conv.valid) begin
            src_q <= conv.src;
            chan_q <= conv.chan;
        end
    end
    // ------------------------------------------------------------
    // Register file, result storage and events
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        hit = 4'h0;
        w1c = 4'h0;
        in_a = 1'b0;
        in_b = 1'b0;
        wd = avs_writedata;
        next_st.ack = (avs_read || avs_write) && !st.ack;
        // D/A may update only while the core is not sampling
        next_st.dac_en = !sampling;
        // Store a finished result
        if (acc_valid) begin
            hit[adcrc_pkg::ST_RESULT] = 1'b1;
            case (src_q)
                adcrc_pkg::ADCRC_SRC_TEMP: next_st.temp = acc_data;
                adcrc_pkg::ADCRC_SRC_IREF: next_st.iref = acc_data;
                adcrc_pkg::ADCRC_SRC_DUP: next_st.dup = acc_data;
                default: begin
                    if (chan_q < adcrc_pkg::CH_GAP_LO || chan_q > adcrc_pkg::CH_GAP_HI) begin
                        next_st.chres[chan_q] = acc_data;
                    end
                end
            endcase
            in_a = acc_data >= st.wina_lo && acc_data <= st.wina_hi;
            in_b = acc_data >= st.winb_lo && acc_data <= st.winb_hi;
            if (compare_en && src_q == adcrc_pkg::ADCRC_SRC_CH) begin
                next_st.wina_st = in_a;
                hit[adcrc_pkg::ST_WINA] = in_a;
                if (chan_q == st.winb_ch) begin
                    next_st.winb_st = in_b;
                    hit[adcrc_pkg::ST_WINB] = in_b;
                end
            end
            if (compare_en && st.buf_en) begin
                next_st.ring[st.buf_ptr] = acc_data;
                next_st.buf_ptr = st.buf_ptr + 4'h1;
                hit[adcrc_pkg::ST_WRAP] = st.buf_ptr == 4'hf;
            end
        end
        // Register writes land on the acknowledge cycle
        // Held until the second cycle so a write lands only with waitrequest low
        if (avs_write && st.ack && avs_byteenable[0]) begin
            case (avs_address)
                adcrc_pkg::OFS_CTRL: begin
                    next_st.fmt.justify_left = wd[0];
                    next_st.fmt.add_count = wd[3:1];
                    next_st.fmt.avg_en = wd[4];
                    next_st.diag = wd[6:5];
                end
                adcrc_pkg::OFS_EXT: begin
                    next_st.temp_acc = wd[0];
                    next_st.iref_acc = wd[1];
                    if (avs_byteenable[1]) begin
                        next_st.trig_a = wd[13:8];
                    end
                    if (avs_byteenable[2]) begin
                        next_st.trig_b = wd[21:16];
                    end
                end
                adcrc_pkg::OFS_STATUS: w1c = wd[3:0];
                adcrc_pkg::OFS_MASK: next_st.mask = wd[3:0];
                adcrc_pkg::OFS_WINB_CH: next_st.winb_ch = wd[4:0];
                adcrc_pkg::OFS_WINB_LO: next_st.winb_lo = wd[15:0];
                adcrc_pkg::OFS_WINB_HI: next_st.winb_hi = wd[15:0];
                adcrc_pkg::OFS_WINA_LO: next_st.wina_lo = wd[15:0];
                adcrc_pkg::OFS_WINA_HI: next_st.wina_hi = wd[15:0];
                adcrc_pkg::OFS_BUF_EN: next_st.buf_en = wd[0];
                adcrc_pkg::OFS_BUF_PTR: next_st.buf_ptr = wd[3:0];
                default: begin
                    if (avs_address >= adcrc_pkg::OFS_SST_BASE && avs_address < adcrc_pkg::OFS_SST_BASE + 10'h030
                        && avs_address[1:0] == 2'h0) begin
                        next_st.sst[4'(avs_address[5:2])] = wd[7:0];
                    end
                end
            endcase
        end
        // Set wins over a clear in the same cycle
        next_st.status = (st.status & ~w1c) | hit;
        // Read data, registered on the acknowledge
        next_st.rdata = 32'h0000_0000;
        if (avs_read && !st.ack) begin
            case (avs_address)
                adcrc_pkg::OFS_CTRL: next_st.rdata = {25'h0, st.diag, st.fmt.avg_en, st.fmt.add_count,
                    st.fmt.justify_left};
                adcrc_pkg::OFS_EXT: next_st.rdata = {10'h0, st.trig_b, 2'h0, st.trig_a, 6'h0, st.iref_acc,
                    st.temp_acc};
                adcrc_pkg::OFS_STATUS: next_st.rdata = {28'h0, st.status};
                adcrc_pkg::OFS_MASK: next_st.rdata = {28'h0, st.mask};
                adcrc_pkg::OFS_WINB_CH: next_st.rdata = {27'h0, st.winb_ch};
                adcrc_pkg::OFS_WINB_LO: next_st.rdata = {16'h0, st.winb_lo};
                adcrc_pkg::OFS_WINB_HI: next_st.rdata = {16'h0, st.winb_hi};
                adcrc_pkg::OFS_WINB_ST: next_st.rdata = {31'h0, st.winb_st};
                adcrc_pkg::OFS_WINMON: next_st.rdata = {30'h0, st.winb_st, st.wina_st};
                adcrc_pkg::OFS_BUF_EN: next_st.rdata = {31'h0, st.buf_en};
                adcrc_pkg::OFS_BUF_PTR: next_st.rdata = {28'h0, st.buf_ptr};
                adcrc_pkg::OFS_DUP: next_st.rdata = {16'h0, st.dup};
                adcrc_pkg::OFS_TEMP: next_st.rdata = {16'h0, st.temp};
                adcrc_pkg::OFS_IREF: next_st.rdata = {16'h0, st.iref};
                adcrc_pkg::OFS_WINA_LO: next_st.rdata = {16'h0, st.wina_lo};
                adcrc_pkg::OFS_WINA_HI: next_st.rdata = {16'h0, st.wina_hi};
                default: begin
                    if (avs_address >= adcrc_pkg::OFS_SST_BASE && avs_address < adcrc_pkg::OFS_SST_BASE + 10'h030) begin
                        next_st.rdata = {24'h0, st.sst[4'(avs_address[5:2])]};
                    end else if (avs_address >= adcrc_pkg::OFS_CH_BASE && avs_address < adcrc_pkg::OFS_BUF_BASE) begin
                        next_st.rdata = {16'h0, st.chres[avs_address[6:2]]}; // Gap channels read zero
                    end else if (avs_address >= adcrc_pkg::OFS_BUF_BASE && avs_address < adcrc_pkg::OFS_BUF_BASE + 10'h040) begin
                        next_st.rdata = {16'h0, st.ring[avs_address[5:2]]};
                    end
                end
            endcase
        end
    end
    // Single state register
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
            st.sst <= {12{adcrc_pkg::SST_RESET}};
            st.diag <= adcrc_pkg::DIAG_0V;
            st.winb_hi <= 16'hffff;
            st.wina_hi <= 16'hffff;
        end else begin
            st <= next_st;
        end
    end
    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // One wait cycle: every access completes on its second cycle
    assign avs_waitrequest = (avs_read || avs_write) && !st.ack;
    assign avs_readdata = st.rdata;
    assign selftest_level_select = st.diag;
    assign group_a_trigger_select = st.trig_a;
    assign group_b_trigger_select = st.trig_b;
    assign dac_sync_enable = st.dac_en;
    assign irq = |(st.status & st.mask);
    // ------------------------------------------------------------
    // Checks on the control logic
    // ------------------------------------------------------------
    // D/A inrush must never fall on a sample
    AST_DAC_GATE: assert property (@(posedge sys_clk) disable iff (!nrst)
        sampling |=> !dac_sync_enable)
        else $error("D/A enabled during sampling");
    // Pointer checks skip bus writes, which may reload the pointer
    AST_PTR_WRAP: assert property (@(posedge sys_clk) disable iff (!nrst)
        (acc_valid && compare_en && st.buf_en && st.buf_ptr == 4'hf && !avs_write) |=> st.buf_ptr == 4'h0)
        else $error("ring pointer did not wrap");
    AST_PTR_STEP: assert property (@(posedge sys_clk) disable iff (!nrst)
        (acc_valid && compare_en && st.buf_en && !avs_write) |=> st.buf_ptr == $past(st.buf_ptr) + 4'h1)
        else $error("ring pointer did not advance");
    // The slot written is the one the pointer showed
    AST_RING_STORE: assert property (@(posedge sys_clk) disable iff (!nrst)
        (acc_valid && compare_en && st.buf_en) |=> st.ring[$past(st.buf_ptr)] == $past(acc_data))
        else $error("ring slot not written");
    // The first and last channels without a result register, 9 and 15, must stay empty
    AST_GAP_EMPTY: assert property (@(posedge sys_clk) disable iff (!nrst)
        st.chres[9] == 16'h0000 && st.chres[15] == 16'h0000)
        else $error("gap channel holds data");
    AST_TEMP_STORE: assert property (@(posedge sys_clk) disable iff (!nrst)
        (acc_valid && src_q == adcrc_pkg::ADCRC_SRC_TEMP) |=> st.temp == $past(acc_data))
        else $error("temperature result not stored");
    // A window B hit survives a clear in the same cycle
    AST_WINB_EVENT: assert property (@(posedge sys_clk) disable iff (!nrst)
        hit[adcrc_pkg::ST_WINB] |=> st.status[adcrc_pkg::ST_WINB])
        else $error("window B event lost");
    // An unmasked wrap raises the interrupt on the next cycle
    AST_IRQ_LEVEL: assert property (@(posedge sys_clk) disable iff (!nrst)
        (hit[adcrc_pkg::ST_WRAP] && st.mask[adcrc_pkg::ST_WRAP] && !avs_write) |=> irq)
        else $error("wrap interrupt missing");
    AST_LEVEL_OUT: assert property (@(posedge sys_clk) disable iff (!nrst)
        (avs_write && st.ack && avs_address == adcrc_pkg::OFS_CTRL && avs_byteenable[0])
        |=> selftest_level_select == $past(avs_writedata[6:5]))
        else $error("selftest level not applied");
    // Trigger fields follow their own byte lanes
    AST_TRIG_A: assert property (@(posedge sys_clk) disable iff (!nrst)
        (avs_write && st.ack && avs_address == adcrc_pkg::OFS_EXT && avs_byteenable[0] && avs_byteenable[1])
        |=> group_a_trigger_select == $past(avs_writedata[13:8]))
        else $error("group A trigger not applied");
    AST_TRIG_B: assert property (@(posedge sys_clk) disable iff (!nrst)
        (avs_write && st.ack && avs_address == adcrc_pkg::OFS_EXT && avs_byteenable[0] && avs_byteenable[2])
        |=> group_b_trigger_select == $past(avs_writedata[21:16]))
        else $error("group B trigger not applied");
    // Excluded inputs finish after one conversion
    AST_IREF_PASS: assert property (@(posedge sys_clk) disable iff (!nrst)
        (conv.valid && conv.src == adcrc_pkg::ADCRC_SRC_IREF && !st.iref_acc) |=> acc_valid)
        else $error("reference input was accumulated");
    AST_TEMP_PASS: assert property (@(posedge sys_clk) disable iff (!nrst)
        (conv.valid && conv.src == adcrc_pkg::ADCRC_SRC_TEMP && !st.temp_acc) |=> acc_valid)
        else $error("temperature input was accumulated");
endmodule
`default_nettype wire

// file: dv/adcrc_core_model.sv
// Behavioural model of the analog conversion core feeding the control block
`timescale 1ns/100ps
`default_nettype none
module adcrc_core_model (
    input wire logic sys_clk, // System clock
    output var adcrc_pkg::adcrc_conv_t conv, // Raw conversion
    output logic sampling // Core is sampling
);
    initial begin
        conv = '0;
        sampling = 1'b0;
    end
    // Sample one cycle, then pulse the result; data is inverted after the pulse so stale values never match
    task automatic send(input adcrc_pkg::adcrc_src_t src, input logic [4:0] ch, input logic [11:0] d);
        @(posedge sys_clk);
        sampling <= 1'b1;
        @(posedge sys_clk);
        sampling <= 1'b0;
        conv <= '{valid: 1'b1, src: src, chan: ch, data: d};
        @(posedge sys_clk);
        conv <= '{valid: 1'b0, src: src, chan: ~ch, data: ~d};
    endtask
    // Long sampling phase during which D/A updates must pause
    task automatic sample(input int n);
        @(posedge sys_clk);
        sampling <= 1'b1;
        repeat (n) @(posedge sys_clk);
        sampling <= 1'b0;
    endtask
endmodule
`default_nettype wire

// file: dv/adcrc_top_tb.sv
// Self-checking testbench of the result and accumulation control block
`timescale 1ns/100ps
`default_nettype none
module adcrc_top_tb;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic [9:0] adr = '0;
    logic rd_en = 1'b0;
    logic wr_en = 1'b0;
    logic [31:0] wdat = '0;
    logic [3:0] be = 4'hf;
    logic [31:0] rdat;
    logic wait_req;
    adcrc_pkg::adcrc_conv_t conv;
    logic sampling;
    logic compare_en = 1'b0;
    logic [1:0] lvl;
    logic [5:0] trg_a;
    logic [5:0] trg_b;
    logic dac_en;
    logic irq;
    int error_cnt = 0;
    int comparisons = 0;
    logic [31:0] rd;
    typedef struct {logic [9:0] a; logic [31:0] e;} adcrc_row_t;
    // ------------------------------------------------------------
    // Reset values, gaps and unmapped places
    // ------------------------------------------------------------
    adcrc_row_t rows [8] = '{'{10'h000, 32'h20}, '{10'h004, 32'h0}, '{10'h040, 32'h0d}, '{10'h068, 32'h0d},
        '{10'h018, 32'hffff}, '{10'h028, 32'h0}, '{10'h124, 32'h0}, '{10'h3fc, 32'h0}};
    adcrc_top adcrc_top_i (.sys_clk(sys_clk), .nrst(nrst), .avs_address(adr), .avs_read(rd_en),
        .avs_write(wr_en), .avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(rdat),
        .avs_waitrequest(wait_req), .conv(conv), .sampling(sampling), .compare_en(compare_en),
        .selftest_level_select(lvl), .group_a_trigger_select(trg_a), .group_b_trigger_select(trg_b),
        .dac_sync_enable(dac_en), .irq(irq));
    adcrc_core_model adcrc_core_model_i (.sys_clk(sys_clk), .conv(conv), .sampling(sampling));
    // Clock of 4 ns period
    initial forever #2 sys_clk = ~sys_clk;
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Bus cycle: request held until waitrequest is sampled low at a rising edge; data taken there
    task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d, input logic [3:0] b);
        @(posedge sys_clk);
        adr <= a;
        wr_en <= w;
        rd_en <= !w;
        wdat <= d;
        be <= b;
        @(posedge sys_clk);
        while (wait_req !== 1'b0) @(posedge sys_clk);
        rd = rdat;
        rd_en <= 1'b0;
        wr_en <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hf);
    endtask
    task automatic rc(input string nm, input logic [9:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, 4'hf);
        chk(nm, e, rd);
    endtask
    task automatic sendn(input adcrc_pkg::adcrc_src_t s, input logic [4:0] c, input logic [11:0] d, input int n);
        repeat (n) adcrc_core_model_i.send(s, c, d);
    endtask
    task automatic end_of_test;
        if (error_cnt == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Watchdog far beyond the few hundred cycles the run needs
    initial begin
        #100000;
        error_cnt++;
        end_of_test();
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        @(negedge sys_clk);
        chk("reset_outs", 32'h4, {lvl, dac_en, irq});
        repeat (5) @(posedge sys_clk);
        nrst <= 1'b1;
        foreach (rows[i]) rc("reg", rows[i].a, rows[i].e);
        // Only the defined levels; 00 is never programmed
        for (int l = 1; l < 4; l++) begin
            wr(10'h000, 32'(l) << 5);
            chk("level", 32'(l), 32'(lvl));
        end
        wr(10'h004, 32'h002a1500);
        chk("trig", 32'h152a, {trg_a, 2'h0, trg_b});
        bus(1'b1, 10'h004, 32'h00ffff00, 4'h1);
        chk("trig_refused", 32'h152a, {trg_a, 2'h0, trg_b});
        // Sums and means; only the defined counts 2 and 16 are used
        wr(10'h000, 32'h22);
        adcrc_core_model_i.send(adcrc_pkg::ADCRC_SRC_CH, 5'h03, 12'h100);
        adcrc_core_model_i.send(adcrc_pkg::ADCRC_SRC_CH, 5'h03, 12'h023);
        rc("sum2", 10'h10c, 32'h123);
        wr(10'h000, 32'h23);
        adcrc_core_model_i.send(adcrc_pkg::ADCRC_SRC_CH, 5'h04, 12'h400);
        adcrc_core_model_i.send(adcrc_pkg::ADCRC_SRC_CH, 5'h04, 12'h3ff);
        rc("sum2_left", 10'h110, 32'h1ffc);
        wr(10'h000, 32'h3a);
        sendn(adcrc_pkg::ADCRC_SRC_CH, 5'h10, 12'habc, 16);
        rc("avg16", 10'h140, 32'habc);
        wr(10'h000, 32'h2a);
        sendn(adcrc_pkg::ADCRC_SRC_CH, 5'h11, 12'h0ff, 16);
        rc("sum16", 10'h144, 32'hff0);
        // Temperature and reference bypass addition unless selected
        wr(10'h000, 32'h22);
        wr(10'h004, 32'h0);
        adcrc_core_model_i.send(adcrc_pkg::ADCRC_SRC_IREF, 5'h00, 12'h555);
        rc("iref_single", 10'h034, 32'h555);
        adcrc_core_model_i.send(adcrc_pkg::ADCRC_SRC_TEMP, 5'h00, 12'h321);
        rc("temp_single", 10'h030, 32'h321);
        wr(10'h004, 32'h2);
        adcrc_core_model_i.send(adcrc_pkg::ADCRC_SRC_IREF, 5'h00, 12'h100);
        adcrc_core_model_i.send(adcrc_pkg::ADCRC_SRC_IREF, 5'h00, 12'h001);
        rc("iref_sum", 10'h034, 32'h101);
        // Result event raises the interrupt, write one clears it
        wr(10'h00c, 32'h1);
        chk("irq_set", 32'h1, 32'(irq));
        wr(10'h008, 32'hf);
        chk("irq_clr", 32'h0, 32'(irq));
        // Ring of sixteen wraps on the sixteenth result; the seventeenth lands in slot 0
        wr(10'h000, 32'h20);
        wr(10'h024, 32'h1);
        wr(10'h00c, 32'h8);
        compare_en <= 1'b1;
        for (int i = 0; i < 17; i++) adcrc_core_model_i.send(adcrc_pkg::ADCRC_SRC_CH, 5'h00, 12'(i));
        rc("ptr", 10'h028, 32'h1);
        rc("slot0", 10'h200, 32'h10);
        rc("slot1", 10'h204, 32'h1);
        rc("winmon", 10'h020, 32'h3);
        rc("winb_st", 10'h01c, 32'h1);
        chk("irq_wrap", 32'h1, 32'(irq));
        wr(10'h008, 32'h8);
        chk("irq_wrap_clr", 32'h0, 32'(irq));
        // D/A updates pause while sampling
        fork
            adcrc_core_model_i.sample(4);
            begin
                repeat (3) @(negedge sys_clk);
                chk("dac_hold", 32'h0, 32'(dac_en));
            end
        join
        repeat (3) @(negedge sys_clk);
        chk("dac_free", 32'h1, 32'(dac_en));
        end_of_test();
    end
endmodule
`default_nettype wire
